// *** logic/pmc_cp0_map.svh ***
`ifndef PMC_SYSCTL_MAP_SVH
`define PMC_SYSCTL_MAP_SVH
`define PMC_REG_HWENA 5'h07
`define PMC_REG_BADADDR 5'h08
`define PMC_REG_TALLY 5'h09
`define PMC_REG_MATCH 5'h0b
`define PMC_REG_STATE 5'h0c
`define PMC_REG_REASON 5'h0d
`define PMC_REG_EXCPC 5'h0e
`define PMC_REG_IDENT 5'h0f
`define PMC_REG_SETUP 5'h10
`define PMC_REG_DBGCTL 5'h17
`define PMC_REG_DBGPC 5'h18
`define PMC_REG_ERRPC 5'h1e
`define PMC_REG_SCRATCH 5'h1f
`define PMC_SEL_FIRST 3'h0
`define PMC_SEL_VECSPACE 3'h1
`define PMC_SEL_SHADOWCTL 3'h2
`define PMC_SEL_SHADOWMAP 3'h3
`define PMC_SEL_VECBASE 3'h1
`define PMC_SEL_SETUP1 3'h1
`define PMC_SEL_SETUP2 3'h2
`define PMC_SEL_SETUP3 3'h3
`define PMC_SEL_TRACE1 3'h1
`define PMC_SEL_TRACE2 3'h2
`define PMC_SEL_UTRACE 3'h3
`define PMC_SEL_TRACEBP 3'h4
`define PMC_SEL_DBG2 3'h5
`define PMC_BIT_USER 4
`define PMC_BIT_ERRLVL 2
`define PMC_BIT_EXCLVL 1
`define PMC_BIT_DBGFLAG 30
`define PMC_HWENA_MASK 32'h0000_000f
`define PMC_STATE_RESET 32'h0000_0004
`define PMC_REASON_CODE_LSB 2
`define PMC_EXC_ADDR_ERR_LD 5'h04
`define PMC_EXC_ADDR_ERR_ST 5'h05
`define PMC_USER_TOP 32'h7fff_ffff
`define PMC_PERIPH_BASE 32'hbf80_0000
`define PMC_PERIPH_TOP 32'hbfff_ffff
`define PMC_ZERO 32'h0000_0000
`endif

// *** logic/pmc_pkg.sv ***
`default_nettype none
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_KERNEL,
    PMC_USER,
    PMC_DEBUG
  } pmc_mode_t;

  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic [4:0] regNum;
    logic [2:0] sel;
    logic [31:0] wrData;
  } pmc_move_t;

  typedef struct packed {
    logic valid;
    logic isDebug;
    logic isError;
    logic isAddrErr;
    logic [4:0] code;
    logic [31:0] pc;
    logic [31:0] badAddr;
  } pmc_exc_t;

  typedef struct packed {
    logic valid;
    logic isStore;
    logic isFetch;
    logic [31:0] addr;
  } pmc_access_t;

  typedef struct packed {
    logic [31:0] hwEna;
    logic [31:0] badAddr;
    logic [31:0] tally;
    logic tallyPhase;
    logic [31:0] match;
    logic [31:0] state;
    logic [31:0] reason;
    logic [31:0] excPc;
    logic [31:0] dbgCtl;
    logic [31:0] dbgPc;
    logic [31:0] errPc;
    logic [31:0] scratch;
    logic [31:0] vecSpace;
    logic [31:0] shadowCtl;
    logic [31:0] shadowMap;
    logic [31:0] vecBase;
    logic [31:0] trace1;
    logic [31:0] trace2;
    logic [31:0] utrace;
    logic [31:0] traceBp;
    logic [31:0] dbg2;
    logic [31:0] rdData;
    pmc_mode_t mode;
    logic [31:0] retPc;
    logic retValid;
    logic accDeny;
    logic accAddrErr;
    logic hwReadOk;
    logic privOk;
    logic dbgResOk;
  } pmc_state_t;
endpackage
`default_nettype wire

// *** logic/pmc_privilege_cp0.sv ***
// Operation
// - After reset the core starts in kernel state.
// - Kernel state when debug flag clear and user bit 0 or error/exception level set.
// - User state only with user bit set and both level bits clear.
// - Debug state whenever debug flag reads one.
// - Outside debug state, a non-debug exception sets exception or error level, entering kernel state.
// - Exception return picks saved PC, clears error level, clears exception level if error clear.
// - With user bit set, core resumes user state once both levels clear.
// - Kernel state allows whole address space and privileged instructions.
// - User state denies access to peripheral registers.
// - User state limits accesses to the user segment.
// - Debug state entered only by debug exception; grants kernel plus debug resources.
// - Debug return leaves debug state, clearing the debug flag.
// - No hardware stack; no implicit push or pop.
// - Coprocessor registers reached only by move-from and move-to by register number.
// - Register numbers 0-6, 10, 17-22, 25-29 are reserved with no function.
// - Register 7 holds the hardware-register read enables for user state.
// - Register 8 reports the address of the latest address error.
// - Register 9 is the cycle tally; register 11 the timer match value.
// - Registers 12, 13, 14 hold status, exception cause and exception PC.
// - Registers 23, 24, 30 hold debug control, debug PC and error PC.
// - User access to kernel-only address raises an address error.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cp0_map.svh"

module pmc_privilege_sysctl #(
  parameter logic [31:0] IDENT_VALUE = 32'h0000_0001, // Arbitrary identity value.
  parameter logic [31:0] SETUP_VALUE = 32'h0000_0000,
  parameter logic [31:0] SETUP1_VALUE = 32'h0000_0000,
  parameter logic [31:0] SETUP2_VALUE = 32'h0000_0000,
  parameter logic [31:0] SETUP3_VALUE = 32'h0000_0000,
  parameter int REG_WIDTH = 32
) (
  input wire logic ref_clk, // Core clock, 25 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire pmc_pkg::pmc_move_t move, // Move-to/move-from coprocessor request.
  input wire pmc_pkg::pmc_exc_t exc, // Exception entry event.
  input wire logic excReturn, // Exception return instruction retires.
  input wire logic dbgReturn, // Debug return instruction retires.
  input wire pmc_pkg::pmc_access_t access, // Load, store or fetch address check.
  input wire logic [1:0] hwRegSel, // Hardware register asked by a read instruction.
  output logic [31:0] moveRdData, // Read data for move-from.
  output pmc_pkg::pmc_mode_t mode, // Current privilege state.
  output logic privAllowed, // Privileged instructions permitted.
  output logic debugResAllowed, // Debug hardware resources permitted.
  output logic accessDenied, // Last checked access refused.
  output logic accessAddrErr, // Last checked access raises an address error.
  output logic hwReadAllowed, // Hardware-register read permitted.
  output logic [31:0] returnPc, // Resume address after a return instruction.
  output logic returnValid, // One-cycle pulse with returnPc.
  output logic [31:0] tallyOut, // Cycle tally value.
  output logic [31:0] matchOut // Timer match value.
);
  // The register file is built for full words only.
  if (REG_WIDTH != 32) begin : gWidthCheck
    $error("REG_WIDTH must be 32");
  end

  pmc_pkg::pmc_state_t st_r;
  pmc_pkg::pmc_state_t st_nxt;

  function automatic pmc_pkg::pmc_mode_t modeOf(input logic [31:0] s, input logic [31:0] d);
    if (d[`PMC_BIT_DBGFLAG]) begin
      return pmc_pkg::PMC_DEBUG;
    end
    if (s[`PMC_BIT_USER] && !s[`PMC_BIT_EXCLVL] && !s[`PMC_BIT_ERRLVL]) begin
      return pmc_pkg::PMC_USER;
    end
    return pmc_pkg::PMC_KERNEL;
  endfunction

  always_comb begin
    pmc_pkg::pmc_mode_t cur;
    logic [31:0] rd;
    logic isUser;
    logic userSeg;
    logic periph;
    logic misalign;
    cur = pmc_pkg::PMC_KERNEL;
    rd = `PMC_ZERO;
    isUser = 1'b0;
    userSeg = 1'b0;
    periph = 1'b0;
    misalign = 1'b0;
    st_nxt = st_r;
    cur = modeOf(st_r.state, st_r.dbgCtl);
    isUser = (cur == pmc_pkg::PMC_USER);
    st_nxt.retValid = 1'b0;

    // The tally advances every other clock.
    st_nxt.tallyPhase = ~st_r.tallyPhase;
    if (st_r.tallyPhase) begin
      st_nxt.tally = st_r.tally + 32'h0000_0001;
    end

    // Move-from decode; reserved numbers and unmatched selects read as zero.
    rd = `PMC_ZERO;
    unique case (move.regNum)
      `PMC_REG_HWENA: rd = (move.sel == `PMC_SEL_FIRST) ? st_r.hwEna : `PMC_ZERO;
      `PMC_REG_BADADDR: rd = (move.sel == `PMC_SEL_FIRST) ? st_r.badAddr : `PMC_ZERO;
      `PMC_REG_TALLY: rd = (move.sel == `PMC_SEL_FIRST) ? st_r.tally : `PMC_ZERO;
      `PMC_REG_MATCH: rd = (move.sel == `PMC_SEL_FIRST) ? st_r.match : `PMC_ZERO;
      `PMC_REG_STATE: begin
        case (move.sel)
          `PMC_SEL_FIRST: rd = st_r.state;
          `PMC_SEL_VECSPACE: rd = st_r.vecSpace;
          `PMC_SEL_SHADOWCTL: rd = st_r.shadowCtl;
          `PMC_SEL_SHADOWMAP: rd = st_r.shadowMap;
          default: rd = `PMC_ZERO;
        endcase
      end
      `PMC_REG_REASON: rd = (move.sel == `PMC_SEL_FIRST) ? st_r.reason : `PMC_ZERO;
      `PMC_REG_EXCPC: rd = (move.sel == `PMC_SEL_FIRST) ? st_r.excPc : `PMC_ZERO;
      `PMC_REG_IDENT: begin
        case (move.sel)
          `PMC_SEL_FIRST: rd = IDENT_VALUE;
          `PMC_SEL_VECBASE: rd = st_r.vecBase;
          default: rd = `PMC_ZERO;
        endcase
      end
      `PMC_REG_SETUP: begin
        case (move.sel)
          `PMC_SEL_FIRST: rd = SETUP_VALUE;
          `PMC_SEL_SETUP1: rd = SETUP1_VALUE;
          `PMC_SEL_SETUP2: rd = SETUP2_VALUE;
          `PMC_SEL_SETUP3: rd = SETUP3_VALUE;
          default: rd = `PMC_ZERO;
        endcase
      end
      `PMC_REG_DBGCTL: begin
        case (move.sel)
          `PMC_SEL_FIRST: rd = st_r.dbgCtl;
          `PMC_SEL_TRACE1: rd = st_r.trace1;
          `PMC_SEL_TRACE2: rd = st_r.trace2;
          `PMC_SEL_UTRACE: rd = st_r.utrace;
          `PMC_SEL_TRACEBP: rd = st_r.traceBp;
          `PMC_SEL_DBG2: rd = st_r.dbg2;
          default: rd = `PMC_ZERO;
        endcase
      end
      `PMC_REG_DBGPC: rd = (move.sel == `PMC_SEL_FIRST) ? st_r.dbgPc : `PMC_ZERO;
      `PMC_REG_ERRPC: rd = (move.sel == `PMC_SEL_FIRST) ? st_r.errPc : `PMC_ZERO;
      `PMC_REG_SCRATCH: rd = (move.sel == `PMC_SEL_FIRST) ? st_r.scratch : `PMC_ZERO;
      default: rd = `PMC_ZERO;
    endcase
    // Coprocessor moves are privileged; a user-state move keeps the old read data and writes nothing.
    if (move.rdEn && !isUser) begin
      st_nxt.rdData = rd;
    end

    if (move.wrEn && !isUser && move.sel == `PMC_SEL_FIRST) begin
      case (move.regNum)
        `PMC_REG_HWENA: st_nxt.hwEna = move.wrData & `PMC_HWENA_MASK;
        `PMC_REG_TALLY: st_nxt.tally = move.wrData;
        `PMC_REG_MATCH: st_nxt.match = move.wrData;
        `PMC_REG_STATE: st_nxt.state = move.wrData;
        `PMC_REG_REASON: st_nxt.reason = move.wrData;
        `PMC_REG_EXCPC: st_nxt.excPc = move.wrData;
        // Software may not set the debug flag; only a debug exception does.
        `PMC_REG_DBGCTL: begin
          st_nxt.dbgCtl = move.wrData;
          st_nxt.dbgCtl[`PMC_BIT_DBGFLAG] = st_r.dbgCtl[`PMC_BIT_DBGFLAG];
        end
        `PMC_REG_DBGPC: st_nxt.dbgPc = move.wrData;
        `PMC_REG_ERRPC: st_nxt.errPc = move.wrData;
        `PMC_REG_SCRATCH: st_nxt.scratch = move.wrData;
        default: begin
        end
      endcase
    end else if (move.wrEn && !isUser) begin
      case ({move.regNum, move.sel})
        {`PMC_REG_STATE, `PMC_SEL_VECSPACE}: st_nxt.vecSpace = move.wrData;
        {`PMC_REG_STATE, `PMC_SEL_SHADOWCTL}: st_nxt.shadowCtl = move.wrData;
        {`PMC_REG_STATE, `PMC_SEL_SHADOWMAP}: st_nxt.shadowMap = move.wrData;
        {`PMC_REG_IDENT, `PMC_SEL_VECBASE}: st_nxt.vecBase = move.wrData;
        {`PMC_REG_DBGCTL, `PMC_SEL_TRACE1}: st_nxt.trace1 = move.wrData;
        {`PMC_REG_DBGCTL, `PMC_SEL_TRACE2}: st_nxt.trace2 = move.wrData;
        {`PMC_REG_DBGCTL, `PMC_SEL_UTRACE}: st_nxt.utrace = move.wrData;
        {`PMC_REG_DBGCTL, `PMC_SEL_TRACEBP}: st_nxt.traceBp = move.wrData;
        {`PMC_REG_DBGCTL, `PMC_SEL_DBG2}: st_nxt.dbg2 = move.wrData;
        default: begin
        end
      endcase
    end

    // Address checks; no stack logic exists, pushes are ordinary stores.
    userSeg = (access.addr <= `PMC_USER_TOP);
    periph = (access.addr >= `PMC_PERIPH_BASE) && (access.addr <= `PMC_PERIPH_TOP);
    misalign = (access.addr[1:0] != 2'b00);
    st_nxt.accDeny = 1'b0;
    st_nxt.accAddrErr = 1'b0;
    if (access.valid) begin
      st_nxt.accDeny = isUser && (periph || !userSeg);
      st_nxt.accAddrErr = misalign || (isUser && !userSeg);
      if (misalign || (isUser && !userSeg)) begin
        st_nxt.badAddr = access.addr;
      end
    end
    st_nxt.hwReadOk = !isUser || st_r.hwEna[hwRegSel];

    // Exceptions and returns override software writes in the same cycle.
    if (exc.valid && exc.isDebug) begin
      st_nxt.dbgCtl[`PMC_BIT_DBGFLAG] = 1'b1;
      st_nxt.dbgPc = exc.pc;
    end else if (exc.valid && cur != pmc_pkg::PMC_DEBUG) begin
      if (exc.isError) begin
        st_nxt.state[`PMC_BIT_ERRLVL] = 1'b1;
        st_nxt.errPc = exc.pc;
      end else begin
        st_nxt.state[`PMC_BIT_EXCLVL] = 1'b1;
        if (!st_r.state[`PMC_BIT_EXCLVL]) begin
          st_nxt.excPc = exc.pc;
        end
      end
      st_nxt.reason[`PMC_REASON_CODE_LSB +: 5] = exc.code;
      if (exc.isAddrErr) begin
        st_nxt.badAddr = exc.badAddr;
      end
    end else if (dbgReturn && cur == pmc_pkg::PMC_DEBUG) begin
      st_nxt.dbgCtl[`PMC_BIT_DBGFLAG] = 1'b0;
      st_nxt.retPc = st_r.dbgPc;
      st_nxt.retValid = 1'b1;
    end else if (excReturn && cur == pmc_pkg::PMC_KERNEL) begin
      st_nxt.state[`PMC_BIT_ERRLVL] = 1'b0;
      if (!st_r.state[`PMC_BIT_ERRLVL]) begin
        st_nxt.state[`PMC_BIT_EXCLVL] = 1'b0;
      end
      st_nxt.retPc = st_r.state[`PMC_BIT_ERRLVL] ? st_r.errPc : st_r.excPc;
      st_nxt.retValid = 1'b1;
    end

    st_nxt.mode = modeOf(st_nxt.state, st_nxt.dbgCtl);
    // Permission flags are registered with the mode so that the outputs come from flops.
    st_nxt.privOk = (st_nxt.mode != pmc_pkg::PMC_USER);
    st_nxt.dbgResOk = (st_nxt.mode == pmc_pkg::PMC_DEBUG);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.state <= `PMC_STATE_RESET;
      st_r.mode <= pmc_pkg::PMC_KERNEL;
      st_r.hwReadOk <= 1'b1;
      st_r.privOk <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign moveRdData = st_r.rdData;
  assign mode = st_r.mode;
  assign privAllowed = st_r.privOk;
  assign debugResAllowed = st_r.dbgResOk;
  assign accessDenied = st_r.accDeny;
  assign accessAddrErr = st_r.accAddrErr;
  assign hwReadAllowed = st_r.hwReadOk;
  assign returnPc = st_r.retPc;
  assign returnValid = st_r.retValid;
  assign tallyOut = st_r.tally;
  assign matchOut = st_r.match;
endmodule
`default_nettype wire

// *** sim/pmc_priv_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cp0_map.svh"
module pmc_priv_props (
  input wire logic ref_clk, // Core clock.
  input wire logic rst, // Reset.
  input wire pmc_pkg::pmc_move_t move, // Move request.
  input wire pmc_pkg::pmc_exc_t exc, // Exception event.
  input wire logic dbgReturn, // Debug return.
  input wire logic excReturn, // Exception return.
  input wire pmc_pkg::pmc_access_t access, // Access check.
  input wire logic [31:0] moveRdData, // Read data.
  input wire pmc_pkg::pmc_mode_t mode, // Privilege state.
  input wire logic privAllowed, // Privileged allowed.
  input wire logic debugResAllowed, // Debug resources allowed.
  input wire logic accessDenied, // Access refused.
  input wire logic accessAddrErr, // Address error.
  input wire logic returnValid // Return pulse.
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_plain_exc;
    exc.valid && !exc.isDebug && mode != pmc_pkg::PMC_DEBUG;
  endsequence
  sequence s_dbg_leave;
    mode == pmc_pkg::PMC_DEBUG && dbgReturn && !exc.valid;
  endsequence
  sequence s_user_acc;
    access.valid && mode == pmc_pkg::PMC_USER;
  endsequence
  a_reset_kernel: assert property ($fell(rst) |-> mode == pmc_pkg::PMC_KERNEL)
    else $error("mode after reset is not kernel");
  a_priv_by_mode: assert property (privAllowed == (mode != pmc_pkg::PMC_USER))
    else $error("privilege flag disagrees with mode");
  a_debug_res: assert property (debugResAllowed == (mode == pmc_pkg::PMC_DEBUG))
    else $error("debug resource flag disagrees with mode");
  a_exc_kernel: assert property (s_plain_exc |=> mode == pmc_pkg::PMC_KERNEL)
    else $error("exception did not enter kernel state");
  a_debug_entry: assert property ((mode == pmc_pkg::PMC_DEBUG &&
    $past(mode) != pmc_pkg::PMC_DEBUG) |-> $past(exc.valid && exc.isDebug))
    else $error("debug state entered without debug exception");
  a_debug_leave: assert property (s_dbg_leave |=> mode != pmc_pkg::PMC_DEBUG)
    else $error("debug return did not leave debug state");
  a_ret_cause: assert property (returnValid |-> $past(excReturn || dbgReturn))
    else $error("return pulse without return instruction");
  a_user_periph: assert property (s_user_acc ##0 (access.addr >= `PMC_PERIPH_BASE &&
    access.addr <= `PMC_PERIPH_TOP) |=> accessDenied)
    else $error("user peripheral access not denied");
  a_user_segment: assert property (s_user_acc ##0 access.addr > `PMC_USER_TOP
    |=> accessDenied && accessAddrErr)
    else $error("user access outside user segment not refused");
  a_user_move: assert property (move.rdEn && mode == pmc_pkg::PMC_USER
    |=> $stable(moveRdData))
    else $error("move read served in user state");
endmodule
bind pmc_privilege_sysctl pmc_priv_props pmc_priv_props_inst (.ref_clk(ref_clk), .rst(rst),
  .move(move), .exc(exc), .dbgReturn(dbgReturn), .excReturn(excReturn), .access(access),
  .moveRdData(moveRdData), .mode(mode), .privAllowed(privAllowed),
  .debugResAllowed(debugResAllowed), .accessDenied(accessDenied),
  .accessAddrErr(accessAddrErr), .returnValid(returnValid));
`default_nettype wire

// *** sim/test_privilege_mode_and_cp0_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_privilege_mode_and_cp0_map;
  logic ref_clk, rst, excReturn, dbgReturn, privAllowed, debugResAllowed;
  logic accessDenied, accessAddrErr, hwReadAllowed, returnValid;
  pmc_pkg::pmc_move_t move;
  pmc_pkg::pmc_exc_t exc;
  pmc_pkg::pmc_access_t access;
  pmc_pkg::pmc_mode_t mode;
  logic [1:0] hwRegSel;
  logic [31:0] moveRdData, returnPc, tallyOut, matchOut, d, t0;
  int nMismatch;
  int nChecks;
  localparam logic [31:0] RSV = 32'h3e7e_047f;
  localparam logic [31:0] IDENT = 32'h0000_00a5; // Arbitrary identity value.
  localparam logic [31:0] SETUP1 = 32'h0000_1234;
  localparam logic [31:0] BASE = 32'h5a5a_0000;
  int regs [6] = '{7, 11, 14, 24, 30, 31};
  pmc_privilege_sysctl #(.IDENT_VALUE(IDENT), .SETUP1_VALUE(SETUP1)) pmc_privilege_sysctl_inst (
    .ref_clk(ref_clk), .rst(rst), .move(move), .exc(exc), .excReturn(excReturn),
    .dbgReturn(dbgReturn), .access(access), .hwRegSel(hwRegSel), .moveRdData(moveRdData),
    .mode(mode), .privAllowed(privAllowed), .debugResAllowed(debugResAllowed),
    .accessDenied(accessDenied), .accessAddrErr(accessAddrErr),
    .hwReadAllowed(hwReadAllowed), .returnPc(returnPc), .returnValid(returnValid),
    .tallyOut(tallyOut), .matchOut(matchOut));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task test_done;
    if (nMismatch == 0 && nChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wr(input logic [4:0] r, input logic [2:0] s, input logic [31:0] v);
    @(posedge ref_clk) move <= {1'b0, 1'b1, r, s, v};
    @(posedge ref_clk) move <= '0;
  endtask
  task rd(input logic [4:0] r, input logic [2:0] s, output logic [31:0] v);
    @(posedge ref_clk) move <= {1'b1, 1'b0, r, s, 32'h0000_0000};
    @(posedge ref_clk) move <= '0;
    #1 v = moveRdData;
  endtask
  task rc(input logic [4:0] r, input logic [2:0] s, input logic [31:0] exp);
    rd(r, s, d);
    chk("coproc read", d, exp);
  endtask
  task md(input pmc_pkg::pmc_mode_t m);
    chk("mode", 32'(mode), 32'(m));
  endtask
  task ex(input logic dbg, input logic [31:0] pc, input logic [31:0] ba);
    @(posedge ref_clk) exc <= {1'b1, dbg, 1'b0, ~dbg, 5'h04, pc, ba};
    @(posedge ref_clk) exc <= '0;
    #1;
  endtask
  task ret(input logic dbg, input logic [31:0] pc);
    @(posedge ref_clk) {dbgReturn, excReturn} <= {dbg, ~dbg};
    @(posedge ref_clk) {dbgReturn, excReturn} <= 2'b00;
    #1 chk("return pulse", 32'(returnValid), 32'h0000_0001);
    chk("return pc", returnPc, pc);
  endtask
  task acc(input logic [31:0] a, input logic e);
    @(posedge ref_clk) access <= {1'b1, 1'b0, 1'b0, a};
    @(posedge ref_clk) access <= '0;
    #1 chk("access denied", 32'(accessDenied), 32'(e));
  endtask
  task hw(input logic [1:0] s, input logic e);
    @(posedge ref_clk) hwRegSel <= s;
    @(posedge ref_clk);
    #1 chk("hw read", 32'(hwReadAllowed), 32'(e));
  endtask
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    nMismatch++;
    test_done;
  end
  initial begin
    ref_clk = 0; rst = 1; move = '0; exc = '0; excReturn = 0; dbgReturn = 0;
    access = '0; hwRegSel = 2'h0; nMismatch = 0; nChecks = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    #1 md(pmc_pkg::PMC_KERNEL);
    rc(5'h0c, 3'h0, 32'h0000_0004);
    foreach (regs[i]) begin
      wr(regs[i][4:0], 3'h0, BASE | regs[i]);
      rc(regs[i][4:0], 3'h0, (regs[i] == 7) ? 32'h0000_0007 : (BASE | regs[i]));
    end
    chk("match", matchOut, BASE | 32'h0000_000b);
    for (int i = 0; i < 32; i++) begin
      if (RSV[i]) begin
        wr(i[4:0], 3'h0, 32'hffff_ffff);
        rc(i[4:0], 3'h0, 32'h0000_0000);
      end
    end
    wr(5'h08, 3'h0, 32'hffff_ffff);
    rc(5'h08, 3'h0, 32'h0000_0000);
    rc(5'h0f, 3'h0, IDENT);
    rc(5'h10, 3'h1, SETUP1);
    rc(5'h10, 3'h0, 32'h0000_0000);
    t0 = tallyOut;
    repeat (4) @(posedge ref_clk);
    #1 chk("tally", tallyOut, t0 + 32'h0000_0002);
    acc(32'h0000_0100, 1'b0);
    chk("address error", 32'(accessAddrErr), 32'h0000_0000);
    acc(32'h0000_0102, 1'b0);
    chk("address error", 32'(accessAddrErr), 32'h0000_0001);
    hw(2'h3, 1'b1);
    wr(5'h0c, 3'h0, 32'h0000_0016);
    ret(1'b0, BASE | 32'h0000_001e);
    md(pmc_pkg::PMC_KERNEL);
    rc(5'h0c, 3'h0, 32'h0000_0012);
    ret(1'b0, BASE | 32'h0000_000e);
    md(pmc_pkg::PMC_USER);
    chk("privileged", 32'(privAllowed), 32'h0000_0000);
    acc(32'hbf80_0000, 1'b1);
    chk("address error", 32'(accessAddrErr), 32'h0000_0001);
    acc(32'h0000_1000, 1'b0);
    acc(32'h8000_0000, 1'b1);
    hw(2'h1, 1'b1);
    hw(2'h3, 1'b0);
    wr(5'h0b, 3'h0, 32'h0000_0000);
    #1 chk("match", matchOut, BASE | 32'h0000_000b);
    rc(5'h0e, 3'h0, 32'h0000_0012);
    ex(1'b0, 32'h0000_2000, 32'h0000_3001);
    md(pmc_pkg::PMC_KERNEL);
    rc(5'h0c, 3'h0, 32'h0000_0012);
    rc(5'h08, 3'h0, 32'h0000_3001);
    rc(5'h0e, 3'h0, 32'h0000_2000);
    rd(5'h0d, 3'h0, d);
    chk("cause code", {27'h0, d[6:2]}, 32'h0000_0004);
    ex(1'b1, 32'h0000_4000, 32'h0000_0000);
    md(pmc_pkg::PMC_DEBUG);
    chk("debug resources", 32'(debugResAllowed), 32'h0000_0001);
    rd(5'h17, 3'h0, d);
    chk("debug flag", 32'(d[30]), 32'h0000_0001);
    rc(5'h18, 3'h0, 32'h0000_4000);
    ret(1'b1, 32'h0000_4000);
    md(pmc_pkg::PMC_KERNEL);
    test_done;
  end
endmodule
`default_nettype wire
